// ### hdl/i2c_target_pkg.sv
package i2c_target_pkg;

  // engine states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_ADDR  = 3'b001,
    ST_PTR   = 3'b010,
    ST_WDATA = 3'b011,
    ST_RDATA = 3'b100,
    ST_WAIT  = 3'b101
  } state_t;

  // register select codes
  localparam logic [3:0] REG_COMMON_RD   = 4'h0;
  localparam logic [3:0] REG_COMMON_CTRL = 4'h1;
  localparam logic [3:0] REG_PORT_CTRL1  = 4'h2;
  localparam logic [3:0] REG_PORT_CTRL2  = 4'h3;
  localparam logic [3:0] REG_RD_FIRST    = 4'h4;
  localparam logic [3:0] REG_RD_LAST     = 4'hd;
  localparam logic [3:0] REG_TEST        = 4'hf;

  // pointer byte fields
  localparam int PTR_REG_MSB = 6;
  localparam int PTR_REG_LSB = 3;
  localparam int PTR_PORT_MSB = 1;
  localparam int PTR_PORT_LSB = 0;

  // address byte fields
  localparam int ADDR_SEL_MSB = 4;
  localparam int ADDR_SEL_LSB = 0;

  // write data values and fields
  localparam logic [7:0] RAMP_UP_FUNC = 8'h06;
  localparam int SOFT_RESET_BIT = 0;
  localparam int ALL_PORTS_OFF_BIT = 1;
  localparam int NUM_PORTS = 4;
  localparam logic [7:0] REG_RESET = 8'h00;

  // bit positions within a byte frame (count of scl rises)
  localparam logic [3:0] POS_ZERO = 4'h0;
  localparam logic [3:0] POS_ONE = 4'h1;
  localparam logic [3:0] POS_LAST_RD = 4'h6;
  localparam logic [3:0] POS_ADDR_DONE = 4'h7;
  localparam logic [3:0] POS_BYTE_DONE = 4'h8;
  localparam logic [3:0] POS_ACK = 4'h9;

  // pin synchroniser: {straps, supply, sda, scl}
  localparam int SYNC_W = 8;
  localparam logic [7:0] SYNC_RST = 8'h03;

  // power-on-reset timer
  localparam int CLK_PERIOD_NS = 4;
  localparam int POR_TIME_NS = 10000;
  localparam logic [15:0] POR_CYCLES =
    16'((POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

endpackage

// ### hdl/i2c_link_if.sv
interface i2c_link_if;
  logic scl_s;
  logic sda_s;
  logic supply_s;
  logic [4:0] strap_s;
  logic want_low;
  logic link_rst_n;
  logic drive_low;

  modport sync_mp (output scl_s, output sda_s, output supply_s, output strap_s);
  modport drive_mp (input want_low, input link_rst_n, output drive_low);
  modport core_mp (
    input scl_s,
    input sda_s,
    input supply_s,
    input strap_s,
    input drive_low,
    output want_low,
    output link_rst_n
  );
endinterface

// ### hdl/pin_sync.sv
module pin_sync (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // raw pins
  input wire logic scl,
  input wire logic sda_in,
  input wire logic supply_ok,
  input wire logic [4:0] address_strap_pins,
  // synchronised levels
  i2c_link_if.sync_mp lk
);

  logic [i2c_target_pkg::SYNC_W-1:0] raw;
  logic [i2c_target_pkg::SYNC_W-1:0] meta_r;
  logic [i2c_target_pkg::SYNC_W-1:0] sync_r;

  assign raw = {address_strap_pins, supply_ok, sda_in, scl};

  // two flops per pin
  genvar g;
  generate
    for (g = 0; g < i2c_target_pkg::SYNC_W; g++) begin : g_sync
      always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
          meta_r[g] <= i2c_target_pkg::SYNC_RST[g];
          sync_r[g] <= i2c_target_pkg::SYNC_RST[g];
        end else begin
          meta_r[g] <= raw[g];
          sync_r[g] <= meta_r[g];
        end
      end
    end
  endgenerate

  assign lk.scl_s = sync_r[0];
  assign lk.sda_s = sync_r[1];
  assign lk.supply_s = sync_r[2];
  assign lk.strap_s = sync_r[7:3];

endmodule

// ### hdl/link_drive.sv
module link_drive (
  // link clock
  input wire logic scl,
  // drive request and result
  i2c_link_if.drive_mp lk
);

  logic rst_meta_r;
  logic rst_sync_r;
  logic want_meta_r;
  logic drive_r;

  // reset level into the scl domain
  always_ff @(posedge scl) begin
    rst_meta_r <= lk.link_rst_n;
    rst_sync_r <= rst_meta_r;
  end

  // drive request sampled on the rise before it is due
  always_ff @(posedge scl) begin
    if (!rst_sync_r) begin
      want_meta_r <= 1'b0;
    end else begin
      want_meta_r <= lk.want_low;
    end
  end

  // data line changes only while scl is low
  always_ff @(negedge scl) begin
    if (!rst_sync_r) begin
      drive_r <= 1'b0;
    end else begin
      drive_r <= want_meta_r;
    end
  end

  assign lk.drive_low = drive_r;

endmodule

// ### hdl/psm_i2c_target.sv
// Functional notes
// - interface and registers stay reset until supply good and power-on timer done
// - address byte: skip two leading bits, match next five against straps
// - address byte lsb one means read, zero means write
// - on address match drive data low through whole ninth clock
// - second byte is pointer, latched on scl fall after eighth bit
// - pointer acknowledged by driving data low for one clock
// - pointer bits 6..3 select register code
// - pointer bits 1..0 select port; common registers ignore port bits
// - write third byte stored in selected write register and acknowledged
// - read: stop, new start, address with read bit; device acknowledges
// - read byte shifted out msb first, valid at scl rise
// - writing 0x06 to port control 1 calls ramp-up for that port, unless all-ports-off bit 1 of common control is set
// - separate data in and out pins; output only ever pulled low
module psm_i2c_target #(
  parameter logic [15:0] POR_CYCLES = i2c_target_pkg::POR_CYCLES,
  // arbitrary identity values
  parameter logic [1:0] CHIP_ID = 2'h1,
  parameter logic [1:0] CHIP_REV = 2'h0
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic supply_ok,
  // serial link
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [4:0] address_strap_pins,
  // read side
  output logic [3:0] reg_select,
  output logic [1:0] port_select,
  input wire logic [7:0] read_data,
  input wire logic [3:0] port_fault,
  // write registers
  output logic [31:0] port_ctrl1,
  output logic [31:0] port_ctrl2,
  output logic [7:0] common_ctrl,
  output logic [7:0] test_ctrl,
  // events and status
  output logic [3:0] ramp_up_call,
  output logic soft_reset,
  output logic if_ready
);

  i2c_link_if lk ();

  pin_sync u_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .scl(scl),
    .sda_in(sda_in),
    .supply_ok(supply_ok),
    .address_strap_pins(address_strap_pins),
    .lk(lk.sync_mp)
  );

  link_drive u_drive (
    .scl(scl),
    .lk(lk.drive_mp)
  );

  // decoding used in several places
  function automatic logic is_per_port(input logic [3:0] code);
    is_per_port = (code != i2c_target_pkg::REG_COMMON_RD) &&
                  (code != i2c_target_pkg::REG_COMMON_CTRL) &&
                  (code != i2c_target_pkg::REG_TEST);
  endfunction

  function automatic logic is_readable(input logic [3:0] code);
    is_readable = (code >= i2c_target_pkg::REG_RD_FIRST) &&
                  (code <= i2c_target_pkg::REG_RD_LAST);
  endfunction

  // power-on reset
  logic [15:0] por_cnt_r;
  logic active_r;
  logic soft_reset_r;
  logic por_hold;

  assign por_hold = !rst_n || !lk.supply_s || soft_reset_r;

  always_ff @(posedge sys_clk) begin
    if (por_hold) begin
      por_cnt_r <= 16'h0000;
      active_r <= 1'b0;
    end else begin
      if (por_cnt_r != POR_CYCLES) begin
        por_cnt_r <= 16'(por_cnt_r + 16'h0001);
      end
      active_r <= (por_cnt_r == POR_CYCLES);
    end
  end

  assign lk.link_rst_n = active_r;

  // bus events
  logic scl_d_r;
  logic sda_d_r;
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;

  always_ff @(posedge sys_clk) begin
    if (!active_r) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= lk.scl_s;
      sda_d_r <= lk.sda_s;
    end
  end

  assign scl_rise = lk.scl_s && !scl_d_r;
  assign scl_fall = !lk.scl_s && scl_d_r;
  assign start_ev = lk.scl_s && scl_d_r && sda_d_r && !lk.sda_s;
  assign stop_ev = lk.scl_s && scl_d_r && !sda_d_r && lk.sda_s;

  // engine state
  i2c_target_pkg::state_t state_r;
  i2c_target_pkg::state_t state_nxt;
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic [3:0] cnt_inc;
  logic [7:0] shift_r;
  logic [7:0] shift_nxt;
  logic [7:0] ptr_r;
  logic [7:0] ptr_nxt;
  logic [7:0] rd_byte_r;
  logic [7:0] rd_byte_nxt;
  logic match_r;
  logic match_nxt;
  logic rw_r;
  logic rw_nxt;
  logic want_r;
  logic want_nxt;
  logic busy;
  logic addr_hit;

  logic [3:0] ptr_code;
  logic [1:0] ptr_port;
  logic [7:0] read_mux;
  logic [7:0] common_rd;

  assign ptr_code = ptr_r[i2c_target_pkg::PTR_REG_MSB:i2c_target_pkg::PTR_REG_LSB];
  assign ptr_port = ptr_r[i2c_target_pkg::PTR_PORT_MSB:i2c_target_pkg::PTR_PORT_LSB];

  assign common_rd = {port_fault, CHIP_REV, CHIP_ID};
  assign read_mux = (ptr_code == i2c_target_pkg::REG_COMMON_RD) ? common_rd :
                    is_readable(ptr_code) ? read_data : 8'h00;

  assign busy = (state_r != i2c_target_pkg::ST_IDLE) && (state_r != i2c_target_pkg::ST_WAIT);
  assign cnt_inc = 4'(cnt_r + 4'h1);
  // five strap bits, leading two skipped
  assign addr_hit = (shift_nxt[i2c_target_pkg::ADDR_SEL_MSB:i2c_target_pkg::ADDR_SEL_LSB] ==
                     lk.strap_s);

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    shift_nxt = shift_r;
    ptr_nxt = ptr_r;
    rd_byte_nxt = rd_byte_r;
    match_nxt = match_r;
    rw_nxt = rw_r;
    want_nxt = want_r;
    if (start_ev) begin
      state_nxt = i2c_target_pkg::ST_ADDR;
      cnt_nxt = i2c_target_pkg::POS_ZERO;
      match_nxt = 1'b0;
      want_nxt = 1'b0;
    end else if (stop_ev) begin
      state_nxt = i2c_target_pkg::ST_IDLE;
      cnt_nxt = i2c_target_pkg::POS_ZERO;
      want_nxt = 1'b0;
    end else if (scl_rise && busy) begin
      cnt_nxt = cnt_inc;
      if (cnt_r < i2c_target_pkg::POS_BYTE_DONE) begin
        shift_nxt = {shift_r[6:0], lk.sda_s};
      end
      // drive value scheduled two bit periods ahead
      case (state_r)
        i2c_target_pkg::ST_ADDR: begin
          if (cnt_inc == i2c_target_pkg::POS_ADDR_DONE) begin
            match_nxt = addr_hit;
            want_nxt = addr_hit;
          end else if (cnt_inc == i2c_target_pkg::POS_BYTE_DONE) begin
            rw_nxt = lk.sda_s;
            rd_byte_nxt = read_mux;
            want_nxt = match_r && lk.sda_s && !read_mux[7];
          end else if (cnt_inc == i2c_target_pkg::POS_ACK) begin
            want_nxt = match_r && rw_r && !rd_byte_r[6];
          end
        end
        i2c_target_pkg::ST_RDATA: begin
          if (cnt_inc <= i2c_target_pkg::POS_LAST_RD) begin
            want_nxt = !rd_byte_r[3'(i2c_target_pkg::POS_LAST_RD - cnt_inc)];
          end else begin
            want_nxt = 1'b0;
          end
        end
        i2c_target_pkg::ST_PTR, i2c_target_pkg::ST_WDATA: begin
          if (cnt_inc == i2c_target_pkg::POS_ADDR_DONE) begin
            want_nxt = 1'b1;
          end else if (cnt_inc == i2c_target_pkg::POS_BYTE_DONE) begin
            want_nxt = 1'b0;
          end
        end
        default: begin
          want_nxt = 1'b0;
        end
      endcase
    end else if (scl_fall && busy && cnt_r == i2c_target_pkg::POS_BYTE_DONE) begin
      // pointer latched on fall after eighth bit
      if (state_r == i2c_target_pkg::ST_PTR) begin
        ptr_nxt = shift_r;
      end
    end else if (scl_fall && busy && cnt_r == i2c_target_pkg::POS_ACK) begin
      cnt_nxt = i2c_target_pkg::POS_ZERO;
      case (state_r)
        i2c_target_pkg::ST_ADDR: begin
          // pointer after write address, read data after read address, or ignore
          if (!match_r) begin
            state_nxt = i2c_target_pkg::ST_WAIT;
          end else if (rw_r) begin
            state_nxt = i2c_target_pkg::ST_RDATA;
          end else begin
            state_nxt = i2c_target_pkg::ST_PTR;
          end
        end
        i2c_target_pkg::ST_PTR: begin
          state_nxt = i2c_target_pkg::ST_WDATA;
        end
        default: begin
          state_nxt = i2c_target_pkg::ST_WAIT;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!active_r) begin
      state_r <= i2c_target_pkg::ST_IDLE;
      cnt_r <= i2c_target_pkg::POS_ZERO;
      shift_r <= i2c_target_pkg::REG_RESET;
      ptr_r <= i2c_target_pkg::REG_RESET;
      rd_byte_r <= i2c_target_pkg::REG_RESET;
      match_r <= 1'b0;
      rw_r <= 1'b0;
      want_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      shift_r <= shift_nxt;
      ptr_r <= ptr_nxt;
      rd_byte_r <= rd_byte_nxt;
      match_r <= match_nxt;
      rw_r <= rw_nxt;
      want_r <= want_nxt;
    end
  end

  assign lk.want_low = want_r;

  // output pin only ever pulls low
  assign sda_out = 1'b0;
  assign sda_oe = lk.drive_low && busy && active_r;

  // write decode
  logic wr_fire;
  logic [7:0] ctrl1_r [i2c_target_pkg::NUM_PORTS];
  logic [7:0] ctrl2_r [i2c_target_pkg::NUM_PORTS];
  logic [3:0] ramp_r;
  logic [7:0] common_ctrl_r;
  logic [7:0] test_ctrl_r;
  logic common_ctrl_hit;

  assign wr_fire = scl_fall && (state_r == i2c_target_pkg::ST_WDATA) &&
                   (cnt_r == i2c_target_pkg::POS_BYTE_DONE);
  assign common_ctrl_hit = wr_fire && (ptr_code == i2c_target_pkg::REG_COMMON_CTRL);

  genvar p;
  generate
    for (p = 0; p < i2c_target_pkg::NUM_PORTS; p++) begin : g_port
      logic port_hit;
      // per-port writes reach only their port
      assign port_hit = wr_fire && is_per_port(ptr_code) && (ptr_port == 2'(p));
      always_ff @(posedge sys_clk) begin
        if (!active_r) begin
          ctrl1_r[p] <= i2c_target_pkg::REG_RESET;
          ctrl2_r[p] <= i2c_target_pkg::REG_RESET;
          ramp_r[p] <= 1'b0;
        end else begin
          if (port_hit && ptr_code == i2c_target_pkg::REG_PORT_CTRL1) begin
            ctrl1_r[p] <= shift_r;
          end
          if (port_hit && ptr_code == i2c_target_pkg::REG_PORT_CTRL2) begin
            ctrl2_r[p] <= shift_r;
          end
          ramp_r[p] <= port_hit && (ptr_code == i2c_target_pkg::REG_PORT_CTRL1) &&
                       (shift_r == i2c_target_pkg::RAMP_UP_FUNC) &&
                       !common_ctrl_r[i2c_target_pkg::ALL_PORTS_OFF_BIT];
        end
      end
      assign port_ctrl1[p*8 +: 8] = ctrl1_r[p];
      assign port_ctrl2[p*8 +: 8] = ctrl2_r[p];
    end
  endgenerate

  always_ff @(posedge sys_clk) begin
    if (!active_r) begin
      common_ctrl_r <= i2c_target_pkg::REG_RESET;
      test_ctrl_r <= i2c_target_pkg::REG_RESET;
      soft_reset_r <= 1'b0;
    end else begin
      if (common_ctrl_hit) begin
        common_ctrl_r <= shift_r;
      end
      if (wr_fire && ptr_code == i2c_target_pkg::REG_TEST) begin
        test_ctrl_r <= shift_r;
      end
      // software reset restarts the power-on timer
      soft_reset_r <= common_ctrl_hit && shift_r[i2c_target_pkg::SOFT_RESET_BIT];
    end
  end

  assign reg_select = ptr_code;
  assign port_select = is_per_port(ptr_code) ? ptr_port : 2'h0;
  assign common_ctrl = common_ctrl_r;
  assign test_ctrl = test_ctrl_r;
  assign ramp_up_call = ramp_r;
  assign soft_reset = soft_reset_r;
  assign if_ready = active_r;

endmodule

// ### sim/psm_i2c_target_chk.sv
module psm_i2c_target_chk #(
  parameter logic [15:0] POR_CYCLES = 16'h0010
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic supply_ok,
  // serial link
  input wire logic scl,
  input wire logic sda_out,
  input wire logic sda_oe,
  // selection and registers
  input wire logic [3:0] reg_select,
  input wire logic [1:0] port_select,
  input wire logic [31:0] port_ctrl1,
  // events and status
  input wire logic [3:0] ramp_up_call,
  input wire logic soft_reset,
  input wire logic if_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic [15:0] wait_r;
  logic [1:0] rport_r;
  wire [1:0] rport = {|ramp_up_call[3:2], ramp_up_call[3] | ramp_up_call[1]};
  always_ff @(posedge sys_clk) begin
    wait_r <= (!rst_n || if_ready) ? 16'h0000 : wait_r + {15'h0000, wait_r != 16'hffff};
    rport_r <= rport;
  end
  rst_quiet_a: assert property (disable iff (1'b0) !rst_n |=> !if_ready && !sda_oe)
    else $error("active after reset");
  ready_quiet_a: assert property (!if_ready |-> !sda_oe)
    else $error("drive before ready");
  supply_drop_a: assert property (!supply_ok [*4] |-> !if_ready)
    else $error("ready without supply");
  por_wait_a: assert property ($rose(if_ready) |-> wait_r >= POR_CYCLES)
    else $error("power-on wait short");
  soft_rst_a: assert property (soft_reset |-> ##[1:4] !if_ready)
    else $error("soft reset ignored");
  oe_rise_a: assert property ($rose(sda_oe) |-> !scl)
    else $error("drive began with clock high");
  oe_hold_a: assert property (scl && $past(scl) |-> $stable(sda_oe))
    else $error("data moved with clock high");
  pull_low_a: assert property (sda_out == 1'b0)
    else $error("output driven high");
  common_port_a: assert property (reg_select inside {4'h0, 4'h1, 4'hf} |-> port_select == 2'h0)
    else $error("port kept for common code");
  ramp_pulse_a: assert property (|ramp_up_call |-> $onehot(ramp_up_call) ##1 !ramp_up_call)
    else $error("ramp call not one pulse");
  ramp_value_a: assert property (|ramp_up_call |=> port_ctrl1[8*rport_r +: 8] == 8'h06)
    else $error("ramp call without value");
  cover property (|ramp_up_call);
  cover property (sda_oe && reg_select == 4'h4);
  cover property (soft_reset);
endmodule

bind psm_i2c_target psm_i2c_target_chk #(.POR_CYCLES(POR_CYCLES)) chk_i (
  .sys_clk(sys_clk), .rst_n(rst_n), .supply_ok(supply_ok), .scl(scl),
  .sda_out(sda_out), .sda_oe(sda_oe), .reg_select(reg_select),
  .port_select(port_select), .port_ctrl1(port_ctrl1), .ramp_up_call(ramp_up_call),
  .soft_reset(soft_reset), .if_ready(if_ready)
);

// ### sim/i2c_host_model.sv
module i2c_host_model (
  // serial link
  output logic scl,
  output wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sda_h = 1'b1;
  initial scl = 1'b1;
  assign sda_in = sda_h & (sda_oe ? sda_out : 1'b1);
  task automatic bitx(input logic b, output logic r);
    sda_h = b;
    #31.25 scl = 1'b1;
    #31.25 r = sda_in;
    #31.25 scl = 1'b0;
    #31.25;
  endtask
  // idle clocks let the link side leave reset
  task automatic idle();
    repeat (2) begin
      #31.25 scl = 1'b0;
      #31.25 scl = 1'b1;
    end
  endtask
  task automatic start();
    sda_h = 1'b1;
    #31.25 scl = 1'b1;
    #62.5 sda_h = 1'b0;
    #62.5 scl = 1'b0;
    #31.25;
  endtask
  task automatic stop();
    sda_h = 1'b0;
    #31.25 scl = 1'b1;
    #62.5 sda_h = 1'b1;
    #62.5;
  endtask
  // msb first, line left high on ninth bit
  task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic a);
    for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
    bitx(1'b1, a);
  endtask
endmodule

// ### sim/i2c_slave_port_register_access_tb_top.sv
module i2c_slave_port_register_access_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic supply_ok = 1'b1;
  logic [4:0] straps = 5'h00;
  logic [7:0] read_data = 8'h00;
  logic [3:0] port_fault = 4'h0;
  wire scl, sda_in, sda_out, sda_oe, soft_reset, if_ready;
  wire [3:0] reg_select, ramp_up_call;
  wire [1:0] port_select;
  wire [31:0] port_ctrl1, port_ctrl2;
  wire [7:0] common_ctrl, test_ctrl;
  logic [3:0] ramp_seen = 4'h0;
  logic lo_seen = 1'b0;
  logic [31:0] pc1, pc2;
  logic [7:0] cc, tc, salt, q;
  logic [3:0] wcodes [7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'he, 4'hf};
  int bad_count = 0;
  int total_checks = 0;
  initial forever #2 sys_clk = ~sys_clk;
  i2c_host_model host (.scl(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe));
  // arbitrary identity values
  psm_i2c_target #(.POR_CYCLES(16'h0010), .CHIP_ID(2'h1), .CHIP_REV(2'h3)) dut (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .supply_ok(supply_ok),
    .scl(scl),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .address_strap_pins(straps),
    .reg_select(reg_select),
    .port_select(port_select),
    .read_data(read_data),
    .port_fault(port_fault),
    .port_ctrl1(port_ctrl1),
    .port_ctrl2(port_ctrl2),
    .common_ctrl(common_ctrl),
    .test_ctrl(test_ctrl),
    .ramp_up_call(ramp_up_call),
    .soft_reset(soft_reset),
    .if_ready(if_ready)
  );
  function automatic logic [7:0] ext_byte(input logic [3:0] c, input logic [1:0] p);
    return {c, 2'b00, p} ^ salt;
  endfunction
  function automatic logic [7:0] exp_read(input logic [3:0] c, input logic [1:0] p);
    if (c == 4'h0) return {port_fault, 4'hd};
    if (c >= 4'h4 && c <= 4'hd) return ext_byte(c, p);
    return 8'h00;
  endfunction
  always @(negedge sys_clk) read_data <= ext_byte(reg_select, port_select);
  always @(posedge sys_clk) ramp_seen <= ramp_seen | ramp_up_call;
  always @(posedge sys_clk) lo_seen <= lo_seen | !if_ready;
  task automatic print_verdict();
    if (bad_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    total_checks++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic regs_chk();
    chk("port_ctrl1", pc1, port_ctrl1);
    chk("port_ctrl2", pc2, port_ctrl2);
    chk("common_test", {16'h0000, cc, tc}, {16'h0000, common_ctrl, test_ctrl});
  endtask
  task automatic wait_rdy();
    for (int i = 0; i < 200 && if_ready !== 1'b1; i++) @(negedge sys_clk);
    chk("if_ready", 32'h1, 32'(if_ready));
    #2000;
    host.idle();
  endtask
  function automatic logic [7:0] adr(input logic [4:0] s, input logic r);
    return {2'($urandom), s, r};
  endfunction
  task automatic wr(input logic [7:0] ptr, input logic [7:0] d, input logic [4:0] s,
                    output logic [2:0] a);
    host.start();
    host.xfer(adr(s, 1'b0), q, a[2]);
    host.xfer(ptr, q, a[1]);
    host.xfer(d, q, a[0]);
    host.stop();
  endtask
  // pointer frame, stop, then address read and data
  task automatic rd(input logic [7:0] ptr, output logic [7:0] v, output logic [3:0] a);
    host.start();
    host.xfer(adr(straps, 1'b0), q, a[3]);
    host.xfer(ptr, q, a[2]);
    host.stop();
    host.start();
    host.xfer(adr(straps, 1'b1), q, a[1]);
    host.xfer(8'hff, v, a[0]);
    host.stop();
  endtask
  initial begin
    #250000;
    bad_count++;
    print_verdict();
  end
  initial begin
    logic [2:0] a3;
    logic [3:0] a4, c;
    logic [1:0] p;
    logic [7:0] d, v;
    void'($urandom(18157));
    salt = 8'($urandom);
    straps = 5'($urandom);
    {pc1, pc2, cc, tc} = '0;
    repeat (6) @(negedge sys_clk);
    rst_n = 1'b1;
    regs_chk();
    wait_rdy();
    for (int i = 0; i < 13; i++) begin
      c = wcodes[$urandom_range(0, 6)];
      p = 2'($urandom);
      d = 8'($urandom);
      if (i < 4) {c, p, d} = {4'h2, 2'(i), 8'h06};
      if (c == 4'h1) d[1:0] = 2'b00;
      @(negedge sys_clk);
      ramp_seen = 4'h0;
      wr({1'($urandom), c, 1'($urandom), p}, d, i < 12 ? straps : straps ^ 5'h11, a3);
      if (i < 12) apply(c, p, d);
      chk("ack", i < 12 ? 32'h0 : 32'h7, 32'(a3));
      if (i < 12) chk("reg_select", 32'(c), 32'(reg_select));
      if (i < 12) chk("port_sel", (c < 4'h2 || c == 4'hf) ? 0 : 32'(p), 32'(port_select));
      repeat (4) @(negedge sys_clk);
      chk("ramp", 32'((i < 12 && c == 4'h2 && d == 8'h06) ? 4'h1 << p : 4'h0), 32'(ramp_seen));
      regs_chk();
    end
    for (int k = 0; k < 16; k++) begin
      c = 4'(k);
      p = 2'($urandom);
      @(negedge sys_clk);
      port_fault = 4'($urandom);
      rd({1'($urandom), c, 1'($urandom), p}, v, a4);
      chk("read acks", 32'h1, 32'(a4));
      chk("read byte", 32'(exp_read(c, p)), 32'(v));
    end
    @(negedge sys_clk);
    lo_seen = 1'b0;
    wr({1'b0, 4'h1, 3'h0}, 8'h01, straps, a3);
    chk("soft reset", 32'h1, 32'(lo_seen));
    wait_rdy();
    {pc1, pc2, cc, tc} = '0;
    regs_chk();
    @(negedge sys_clk);
    ramp_seen = 4'h0;
    wr({1'b0, 4'h1, 3'h0}, 8'h02, straps, a3);
    apply(4'h1, 2'h0, 8'h02);
    wr({1'b0, 4'h2, 3'h2}, 8'h06, straps, a3);
    apply(4'h2, 2'h2, 8'h06);
    wr({1'b0, 4'h3, 3'h1}, 8'h5a, straps, a3);
    apply(4'h3, 2'h1, 8'h5a);
    chk("ramp off", 32'h0, 32'(ramp_seen));
    chk("ack", 32'h0, 32'(a3));
    regs_chk();
    @(negedge sys_clk);
    supply_ok = 1'b0;
    repeat (8) @(negedge sys_clk);
    chk("ready off", 32'h0, 32'(if_ready));
    {pc1, pc2, cc, tc} = '0;
    regs_chk();
    supply_ok = 1'b1;
    wait_rdy();
    print_verdict();
  end
  task automatic apply(input logic [3:0] c, input logic [1:0] p, input logic [7:0] d);
    case (c)
      4'h1: cc = d;
      4'h2: pc1[8*p +: 8] = d;
      4'h3: pc2[8*p +: 8] = d;
      4'hf: tc = d;
      default: ;
    endcase
  endtask
endmodule
